/* rtl/nam_core.sv */
// Nibble ALU, shift and move datapath with data memory and working registers
`timescale 1ns/1ps
// Functional notes
// - Memory-to-working move copies direct memory nibble to result and working register.
// - Pointer form copies direct memory nibble to result and memory at pointer.
// - Working-to-memory move copies working register or pointed nibble to result and memory.
// - Right shifts move bits toward bit 0, fill bit 3 with 0 or 1.
// - Left shifts move bits toward bit 3, fill bit 0 with 0 or 1.
// - Bit3-to-carry move loads carry from operand bit 3 only.
// - Flag move writes carry, result-was-zero, two zeros to result and memory.
// - Increment adds one, writes operand and result, updates carry.
// - Decrement subtracts one, writes operand and result, updates carry.
// - Add with carry sums operand, result, carry; optional write-back.
// - Subtract with carry: operand plus inverted result plus carry; optional write-back.
// - Minus: operand plus inverted result plus one; optional write-back.
// - Sum adds operand and result without carry-in, updates carry.
// - Sum keeping carry adds operand and result, carry untouched.
// - Conjunction ANDs operand with result; optional write-back.
// - Eight-bit index pointer addresses all memory for pointer forms.
module nam_core #(
   parameter int MEM_DEPTH = nam_pkg::MEM_DEPTH,
   parameter int WR_DEPTH  = nam_pkg::WR_DEPTH
) (
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire logic                       cmd_valid,
   input  wire nam_pkg::nam_cmd_t          cmd,
   input  wire nam_pkg::nam_ptr_load_t     ptr_load,
   input  wire logic [nam_pkg::PTR_W-1:0]  peek_mem_addr,
   input  wire logic [nam_pkg::WR_SEL_W-1:0] peek_wr_sel,
   output logic [nam_pkg::NIB_W-1:0]       result_nibble,
   output logic                            carry_flag,
   output logic [nam_pkg::PTR_W-1:0]       index_pointer,
   output logic                            cmd_done,
   output logic [nam_pkg::NIB_W-1:0]       peek_mem_data,
   output logic [nam_pkg::NIB_W-1:0]       peek_wr_data
);

   // Four-bit adder with carry in; bit 4 is the carry out
   function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
      add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction

   // Storage arrays are data, not control, so they carry no reset
   logic [3:0] mem_arr [MEM_DEPTH];
   logic [3:0] wr_arr  [WR_DEPTH];

   logic [3:0]  result_ff;
   logic [3:0]  nxt_result;
   logic        carry_ff;
   logic        nxt_carry;
   logic [7:0]  ptr_ff;
   logic [7:0]  nxt_ptr;
   logic        done_ff;
   logic        nxt_done;
   logic [3:0]  peek_mem_ff;
   logic [3:0]  nxt_peek_mem;
   logic [3:0]  peek_wr_ff;
   logic [3:0]  nxt_peek_wr;

   logic [7:0]  opnd_addr;
   logic [3:0]  dir_val;
   logic [3:0]  opnd_val;
   logic [3:0]  work_val;
   logic [4:0]  sum;
   logic        mem_we;
   logic [7:0]  mem_wa;
   logic [3:0]  mem_wd;
   logic        wr_we;
   logic [3:0]  wr_wd;

   // Operand selection: direct address or index pointer
   always_comb begin
      opnd_addr = cmd.use_ptr ? ptr_ff : cmd.mem_addr;
      dir_val   = mem_arr[cmd.mem_addr];
      opnd_val  = mem_arr[opnd_addr];
      work_val  = wr_arr[cmd.wr_sel];
   end

   // Datapath next values
   always_comb begin
      nxt_result = result_ff;
      nxt_carry  = carry_ff;
      nxt_done   = cmd_valid;
      mem_we     = 1'b0;
      mem_wa     = opnd_addr;
      mem_wd     = nam_pkg::RST_NIBBLE;
      wr_we      = 1'b0;
      wr_wd      = nam_pkg::RST_NIBBLE;
      sum        = 5'h00;
      if (cmd_valid) begin
         case (cmd.op)
            nam_pkg::OP_MEM_TO_WORK: begin
               nxt_result = dir_val;
               if (cmd.use_ptr) begin
                  mem_we = 1'b1;
                  mem_wa = ptr_ff;
                  mem_wd = dir_val;
               end else begin
                  wr_we = 1'b1;
                  wr_wd = dir_val;
               end
            end
            nam_pkg::OP_WORK_TO_MEM: begin
               nxt_result = cmd.use_ptr ? opnd_val : work_val;
               mem_we     = 1'b1;
               mem_wa     = cmd.mem_addr;
               mem_wd     = cmd.use_ptr ? opnd_val : work_val;
            end
            nam_pkg::OP_SHR_ZERO, nam_pkg::OP_SHR_ONE: begin
               nxt_result = {cmd.op == nam_pkg::OP_SHR_ONE, opnd_val[3:1]};
               mem_we     = 1'b1;
               mem_wd     = nxt_result;
            end
            nam_pkg::OP_SHL_ZERO, nam_pkg::OP_SHL_ONE: begin
               nxt_result = {opnd_val[2:0], cmd.op == nam_pkg::OP_SHL_ONE};
               mem_we     = 1'b1;
               mem_wd     = nxt_result;
            end
            nam_pkg::OP_BIT3_CARRY: begin
               nxt_carry = opnd_val[3];
            end
            nam_pkg::OP_FLAG_MEM: begin
               nxt_result = nam_pkg::RST_NIBBLE;
               nxt_result[nam_pkg::FLAG_CARRY_POS] = carry_ff;
               nxt_result[nam_pkg::FLAG_ZERO_POS]  = (result_ff == nam_pkg::RST_NIBBLE);
               mem_we = 1'b1;
               mem_wd = nxt_result;
            end
            nam_pkg::OP_INC, nam_pkg::OP_DEC: begin
               // Decrement adds all ones, so carry set means no borrow
               sum = add4(opnd_val, (cmd.op == nam_pkg::OP_INC) ? nam_pkg::ONE_NIBBLE
                                                                : nam_pkg::ALL_ONES, 1'b0);
               nxt_result = sum[3:0];
               nxt_carry  = sum[4];
               mem_we     = 1'b1;
               mem_wd     = sum[3:0];
            end
            nam_pkg::OP_ADD_CARRY, nam_pkg::OP_SUB_CARRY, nam_pkg::OP_MINUS,
            nam_pkg::OP_SUM, nam_pkg::OP_SUM_KEEP: begin
               case (cmd.op)
                  nam_pkg::OP_ADD_CARRY: sum = add4(opnd_val, result_ff, carry_ff);
                  nam_pkg::OP_SUB_CARRY: sum = add4(opnd_val, ~result_ff, carry_ff);
                  nam_pkg::OP_MINUS:     sum = add4(opnd_val, ~result_ff, 1'b1);
                  default:               sum = add4(opnd_val, result_ff, 1'b0);
               endcase
               nxt_result = sum[3:0];
               if (cmd.op != nam_pkg::OP_SUM_KEEP) begin
                  nxt_carry = sum[4];
               end
               mem_we = cmd.wback;
               mem_wd = sum[3:0];
            end
            nam_pkg::OP_CONJ: begin
               nxt_result = opnd_val & result_ff;
               mem_we     = cmd.wback;
               mem_wd     = opnd_val & result_ff;
            end
            default: begin
               nxt_result = result_ff;
            end
         endcase
      end
   end

   // Index pointer loads its high nibble, its low nibble or both from one input nibble
   always_comb begin
      nxt_ptr = ptr_ff;
      if (ptr_load.load_hi) begin
         nxt_ptr[7:4] = ptr_load.nibble;
      end
      if (ptr_load.load_lo) begin
         nxt_ptr[3:0] = ptr_load.nibble;
      end
   end

   // Peek ports are registered, so a write shows on them one cycle later
   always_comb begin
      nxt_peek_mem = mem_arr[peek_mem_addr];
      nxt_peek_wr  = wr_arr[peek_wr_sel];
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         result_ff   <= nam_pkg::RST_NIBBLE;
         carry_ff    <= nam_pkg::RST_CARRY;
         ptr_ff      <= nam_pkg::RST_PTR;
         done_ff     <= 1'b0;
         peek_mem_ff <= nam_pkg::RST_NIBBLE;
         peek_wr_ff  <= nam_pkg::RST_NIBBLE;
      end else begin
         result_ff   <= nxt_result;
         carry_ff    <= nxt_carry;
         ptr_ff      <= nxt_ptr;
         done_ff     <= nxt_done;
         peek_mem_ff <= nxt_peek_mem;
         peek_wr_ff  <= nxt_peek_wr;
      end
   end

   // Writes are blocked in reset so a stray command cannot corrupt storage
   always_ff @(posedge sys_clk) begin
      if (rstn && mem_we) begin
         mem_arr[mem_wa] <= mem_wd;
      end
      if (rstn && wr_we) begin
         wr_arr[cmd.wr_sel] <= wr_wd;
      end
   end

   assign result_nibble = result_ff;
   assign carry_flag    = carry_ff;
   assign index_pointer = ptr_ff;
   assign cmd_done      = done_ff;
   assign peek_mem_data = peek_mem_ff;
   assign peek_wr_data  = peek_wr_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   logic is_op;
   assign is_op = cmd_valid;

   property p_mem_to_work;
      is_op && cmd.op == nam_pkg::OP_MEM_TO_WORK |=> result_ff == $past(dir_val);
   endproperty
   a_mem_to_work: assert property (p_mem_to_work) else $error("move result wrong");

   property p_ptr_move_wr;
      is_op && cmd.op == nam_pkg::OP_MEM_TO_WORK && cmd.use_ptr |=> mem_arr[$past(ptr_ff)] == $past(dir_val);
   endproperty
   a_ptr_move_wr: assert property (p_ptr_move_wr) else $error("pointer move not written");

   property p_work_to_mem;
      is_op && cmd.op == nam_pkg::OP_WORK_TO_MEM && !cmd.use_ptr |=> result_ff == $past(work_val);
   endproperty
   a_work_to_mem: assert property (p_work_to_mem) else $error("working move wrong");

   property p_shr;
      is_op && cmd.op == nam_pkg::OP_SHR_ONE |=> result_ff == (($past(opnd_val) >> 1) | 4'h8);
   endproperty
   a_shr: assert property (p_shr) else $error("right shift wrong");

   property p_shl;
      is_op && cmd.op == nam_pkg::OP_SHL_ZERO |=> result_ff == 4'(($past(opnd_val) << 1));
   endproperty
   a_shl: assert property (p_shl) else $error("left shift wrong");

   property p_bit3;
      is_op && cmd.op == nam_pkg::OP_BIT3_CARRY |=> carry_ff == $past(opnd_val[3]) && $stable(result_ff);
   endproperty
   a_bit3: assert property (p_bit3) else $error("bit3 move wrong");

   property p_flag;
      is_op && cmd.op == nam_pkg::OP_FLAG_MEM
      |=> result_ff == {$past(carry_ff), $past(result_ff) == 4'h0, 2'b00};
   endproperty
   a_flag: assert property (p_flag) else $error("flag nibble wrong");

   property p_dec;
      is_op && cmd.op == nam_pkg::OP_DEC |=> carry_ff == ($past(opnd_val) != 4'h0);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement carry wrong");

   property p_sub_carry;
      is_op && cmd.op == nam_pkg::OP_SUB_CARRY
      |=> {carry_ff, result_ff} == add4($past(opnd_val), ~$past(result_ff), $past(carry_ff));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("subtract with carry wrong");

   // Expected sums use plain addition so a broken adder function cannot hide
   property p_inc;
      is_op && cmd.op == nam_pkg::OP_INC |=> {carry_ff, result_ff} == {1'b0, $past(opnd_val)} + 5'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");

   property p_add_carry;
      is_op && cmd.op == nam_pkg::OP_ADD_CARRY
      |=> {carry_ff, result_ff} == {1'b0, $past(opnd_val)} + {1'b0, $past(result_ff)} + {4'h0, $past(carry_ff)};
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

   property p_minus;
      is_op && cmd.op == nam_pkg::OP_MINUS
      |=> {carry_ff, result_ff} == {1'b0, $past(opnd_val)} + {1'b0, ~$past(result_ff)} + 5'h01;
   endproperty
   a_minus: assert property (p_minus) else $error("minus wrong");

   property p_sum;
      is_op && cmd.op == nam_pkg::OP_SUM
      |=> {carry_ff, result_ff} == {1'b0, $past(opnd_val)} + {1'b0, $past(result_ff)};
   endproperty
   a_sum: assert property (p_sum) else $error("sum wrong");

   property p_conj;
      is_op && cmd.op == nam_pkg::OP_CONJ |=> result_ff == ($past(opnd_val) & $past(result_ff)) && $stable(carry_ff);
   endproperty
   a_conj: assert property (p_conj) else $error("conjunction wrong");

   property p_keep;
      is_op && cmd.op == nam_pkg::OP_SUM_KEEP |=> $stable(carry_ff);
   endproperty
   a_keep: assert property (p_keep) else $error("carry changed");

   property p_done;
      is_op |=> done_ff ##1 (done_ff == $past(is_op));
   endproperty
   a_done: assert property (p_done) else $error("done timing wrong");

   c_sum_carry: cover property (is_op && cmd.op == nam_pkg::OP_SUM ##1 carry_ff);
   c_ptr_inc:   cover property (is_op && cmd.op == nam_pkg::OP_INC && cmd.use_ptr);
   c_back2back: cover property (is_op && cmd.wback ##1 is_op && cmd.op == nam_pkg::OP_CONJ);

endmodule // nam_core

/* rtl/nam_pkg.sv */
// Shared types and constants for the nibble ALU and move core
package nam_pkg;

   localparam int NIB_W          = 4;
   localparam int PTR_W          = 8;
   localparam int WR_SEL_W       = 4;
   localparam int MEM_DEPTH      = 256;
   localparam int WR_DEPTH       = 16;

   localparam logic [3:0] RST_NIBBLE  = 4'h0;
   localparam logic [7:0] RST_PTR     = 8'h00;
   localparam logic       RST_CARRY   = 1'b0;
   localparam logic [3:0] ONE_NIBBLE  = 4'h1;
   localparam logic [3:0] ALL_ONES    = 4'hf;

   // Flag nibble layout
   localparam int FLAG_CARRY_POS = 3;
   localparam int FLAG_ZERO_POS  = 2;

   typedef enum logic [4:0] {
      OP_NOP         = 5'h00,
      OP_MEM_TO_WORK = 5'h01,
      OP_WORK_TO_MEM = 5'h02,
      OP_SHR_ZERO    = 5'h03,
      OP_SHR_ONE     = 5'h04,
      OP_SHL_ZERO    = 5'h05,
      OP_SHL_ONE     = 5'h06,
      OP_BIT3_CARRY  = 5'h07,
      OP_FLAG_MEM    = 5'h08,
      OP_INC         = 5'h09,
      OP_DEC         = 5'h0a,
      OP_ADD_CARRY   = 5'h0b,
      OP_SUB_CARRY   = 5'h0c,
      OP_MINUS       = 5'h0d,
      OP_SUM         = 5'h0e,
      OP_SUM_KEEP    = 5'h0f,
      OP_CONJ        = 5'h10
   } nam_op_t;

   typedef struct packed {
      nam_op_t              op;
      logic                 use_ptr;
      logic                 wback;
      logic [PTR_W-1:0]     mem_addr;
      logic [WR_SEL_W-1:0]  wr_sel;
   } nam_cmd_t;

   typedef struct packed {
      logic                 load_hi;
      logic                 load_lo;
      logic [NIB_W-1:0]     nibble;
   } nam_ptr_load_t;

endpackage

/* testbench/testbench.sv */
// Self-checking bench for the nibble ALU and move core
`timescale 1ns/1ps
module testbench;
   logic                  sys_clk = 1'b0;
   logic                  rstn;
   logic                  cmd_valid;
   nam_pkg::nam_cmd_t     cmd;
   nam_pkg::nam_ptr_load_t ptr_load;
   logic [7:0]            peek_mem_addr;
   logic [3:0]            peek_wr_sel;
   logic [3:0]            result_nibble;
   logic                  carry_flag;
   logic [7:0]            index_pointer;
   logic                  cmd_done;
   logic [3:0]            peek_mem_data;
   logic [3:0]            peek_wr_data;
   int                    num_errors = 0;
   int                    checks_done = 0;
   // Reference state
   logic [3:0]            mem [256];
   logic [3:0]            wr [16];
   logic [3:0]            m_acc = 4'h0;
   logic                  m_cf = 1'b0;
   logic [7:0]            m_ptr = 8'h00;

   always #12.5 sys_clk = ~sys_clk;

   nam_core nam_core_i (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .ptr_load(ptr_load),
      .peek_mem_addr(peek_mem_addr), .peek_wr_sel(peek_wr_sel), .result_nibble(result_nibble),
      .carry_flag(carry_flag), .index_pointer(index_pointer), .cmd_done(cmd_done),
      .peek_mem_data(peek_mem_data), .peek_wr_data(peek_wr_data));

   task automatic test_done;
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Entered and left in the time step of a rising edge
   task automatic exec(nam_pkg::nam_op_t op, logic p, logic w, logic [7:0] a, logic [3:0] s, logic b = 1'b0);
      logic [7:0] ea, wa;
      logic [4:0] r;
      logic [3:0] m, n;
      logic       wm, ww;
      ea = p ? m_ptr : a;
      m = mem[ea];
      n = ~m_acc;
      wa = ea;
      r = {m_cf, m_acc};
      wm = 1'b1;
      ww = 1'b0;
      case (op)
         nam_pkg::OP_MEM_TO_WORK: begin
            r[3:0] = mem[a];
            wa = m_ptr;
            wm = p;
            ww = !p;
         end
         nam_pkg::OP_WORK_TO_MEM: begin
            r[3:0] = p ? mem[m_ptr] : wr[s];
            wa = a;
         end
         nam_pkg::OP_SHR_ZERO: r[3:0] = {1'b0, m[3:1]};
         nam_pkg::OP_SHR_ONE: r[3:0] = {1'b1, m[3:1]};
         nam_pkg::OP_SHL_ZERO: r[3:0] = {m[2:0], 1'b0};
         nam_pkg::OP_SHL_ONE: r[3:0] = {m[2:0], 1'b1};
         nam_pkg::OP_BIT3_CARRY: begin
            r[4] = m[3];
            wm = 1'b0;
         end
         nam_pkg::OP_FLAG_MEM: r[3:0] = {m_cf, m_acc == 4'h0, 2'b00};
         nam_pkg::OP_NOP: wm = 1'b0;
         nam_pkg::OP_INC: r = m + 5'h01;
         nam_pkg::OP_DEC: r = m + 5'h0f;
         default: begin
            wm = w;
            case (op)
               nam_pkg::OP_ADD_CARRY: r = m + m_acc + m_cf;
               nam_pkg::OP_SUB_CARRY: r = m + n + m_cf;
               nam_pkg::OP_MINUS: r = m + n + 5'h01;
               nam_pkg::OP_SUM: r = m + m_acc;
               nam_pkg::OP_SUM_KEEP: r[3:0] = m + m_acc;
               default: r[3:0] = m & m_acc;
            endcase
         end
      endcase
      cmd <= '{op, p, w, a, s};
      cmd_valid <= 1'b1;
      m_acc = r[3:0];
      m_cf = r[4];
      if (wm) mem[wa] = r[3:0];
      if (ww) wr[s] = r[3:0];
      @(posedge sys_clk);
      if (!b) begin
         cmd_valid <= 1'b0;
         peek_mem_addr <= wa;
         peek_wr_sel <= s;
         #1;
         cmp("done", 8'h01, {7'h00, cmd_done});
         cmp("result", {4'h0, m_acc}, {4'h0, result_nibble});
         cmp("carry", {7'h00, m_cf}, {7'h00, carry_flag});
         @(posedge sys_clk);
         #1;
         cmp("done_low", 8'h00, {7'h00, cmd_done});
         if (wm) cmp("mem", {4'h0, mem[wa]}, {4'h0, peek_mem_data});
         if (ww) cmp("work", {4'h0, wr[s]}, {4'h0, peek_wr_data});
         @(posedge sys_clk);
      end
   endtask

   // Flag move gives a known start, four shifts then set every bit
   task automatic set_mem(logic [7:0] a, logic [3:0] v);
      exec(nam_pkg::OP_FLAG_MEM, 1'b0, 1'b0, a, 4'h0);
      for (int i = 3; i >= 0; i--)
         exec(v[i] ? nam_pkg::OP_SHL_ONE : nam_pkg::OP_SHL_ZERO, 1'b0, 1'b0, a, 4'h0);
   endtask

   task automatic load_ptr(logic [7:0] v);
      ptr_load <= '{1'b1, 1'b0, v[7:4]};
      @(posedge sys_clk);
      ptr_load <= '{1'b0, 1'b1, v[3:0]};
      @(posedge sys_clk);
      ptr_load <= '{1'b0, 1'b0, 4'h0};
      m_ptr = v;
      #1;
      cmp("pointer", v, index_pointer);
      @(posedge sys_clk);
   endtask

   task automatic t_shift;
      set_mem(8'h50, 4'h6);
      exec(nam_pkg::OP_SHR_ZERO, 1'b0, 1'b0, 8'h50, 4'h0);
      exec(nam_pkg::OP_SHR_ONE, 1'b0, 1'b0, 8'h50, 4'h0);
   endtask

   task automatic t_moves;
      set_mem(8'h10, 4'ha);
      set_mem(8'h11, 4'h5);
      exec(nam_pkg::OP_MEM_TO_WORK, 1'b0, 1'b0, 8'h10, 4'h3);
      load_ptr(8'hf1);
      exec(nam_pkg::OP_MEM_TO_WORK, 1'b1, 1'b0, 8'h11, 4'h3);
      exec(nam_pkg::OP_WORK_TO_MEM, 1'b0, 1'b0, 8'h12, 4'h3);
      exec(nam_pkg::OP_WORK_TO_MEM, 1'b1, 1'b0, 8'h13, 4'h3);
   endtask

   task automatic t_flags;
      set_mem(8'h30, 4'h8);
      exec(nam_pkg::OP_BIT3_CARRY, 1'b0, 1'b0, 8'h30, 4'h0);
      exec(nam_pkg::OP_FLAG_MEM, 1'b0, 1'b0, 8'h31, 4'h0);
      set_mem(8'h32, 4'h0);
      exec(nam_pkg::OP_FLAG_MEM, 1'b0, 1'b0, 8'h33, 4'h0);
      exec(nam_pkg::OP_NOP, 1'b0, 1'b0, 8'h33, 4'h0);
   endtask

   // Wrap points of the adder, then two increments with no gap
   task automatic t_incdec;
      set_mem(8'h40, 4'hf);
      load_ptr(8'h40);
      for (int i = 0; i < 2; i++) begin
         exec(nam_pkg::OP_INC, i[0], 1'b0, 8'h40, 4'h0);
         exec(nam_pkg::OP_DEC, i[0], 1'b0, 8'h40, 4'h0);
      end
      exec(nam_pkg::OP_INC, 1'b0, 1'b0, 8'h40, 4'h0, 1'b1);
      exec(nam_pkg::OP_INC, 1'b0, 1'b0, 8'h40, 4'h0);
   endtask

   task automatic t_alu;
      load_ptr(8'h22);
      for (int i = 0; i < 6; i++)
         for (int k = 0; k < 2; k++) begin
            set_mem(8'h21, k[0] ? 4'h8 : 4'h0);
            exec(nam_pkg::OP_BIT3_CARRY, 1'b0, 1'b0, 8'h21, 4'h0);
            // Operand first, so the move below leaves the result register at 9
            set_mem(8'h22, k[0] ? 4'hc : 4'h3);
            set_mem(8'h20, 4'h9);
            exec(nam_pkg::OP_MEM_TO_WORK, 1'b0, 1'b0, 8'h20, 4'h2);
            exec(nam_pkg::nam_op_t'(5'h0b + i), k[0], k[0], k[0] ? 8'h23 : 8'h22, 4'h2);
         end
   endtask

   task automatic t_reset;
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      cmp("rst_result", 8'h00, {4'h0, result_nibble});
      cmp("rst_carry", 8'h00, {7'h00, carry_flag});
      cmp("rst_pointer", 8'h00, index_pointer);
      cmp("rst_done", 8'h00, {7'h00, cmd_done});
      @(posedge sys_clk);
      rstn <= 1'b1;
      {m_acc, m_cf, m_ptr} = '0;
      @(posedge sys_clk);
      set_mem(8'h60, 4'h7);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      test_done;
   end

   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      ptr_load = '0;
      peek_mem_addr = 8'h00;
      peek_wr_sel = 4'h0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_shift;
      t_moves;
      t_flags;
      t_incdec;
      t_alu;
      t_reset;
      test_done;
   end
endmodule // testbench
